// ==== core/skcmp_pkg.sv ====
// package for the skip-compare instruction decoder
package skcmp_pkg;
    localparam int NIB_W = 4;
    localparam int SEL_BIT = 0;
    localparam logic [1:0] IMM_WORDS = 2'h2;
    localparam logic [3:0] ACC_RST = 4'h0;
    localparam logic [3:0] CTRL_RST = 4'h0;

    typedef enum logic [3:0] {
        SKCMP_OP_OTHER = 4'h1,
        SKCMP_OP_IMM = 4'h2,
        SKCMP_OP_MEM = 4'h4,
        SKCMP_OP_FLAG = 4'h8
    } skcmp_op_t;

    typedef struct packed {
        skcmp_op_t op;
        logic [3:0] imm;
    } skcmp_instr_t;

    typedef enum logic [2:0] {
        SKCMP_EXEC = 3'h1,
        SKCMP_IMM2 = 3'h2,
        SKCMP_SKIP = 3'h4
    } skcmp_state_t;
endpackage

// ==== core/skcmp_decoder.sv ====
// skip-compare instruction execution and skip control
// Overview of operation
// - acc equals immediate: skip; two words, two cycles
// - acc differs from immediate: next executes
// - acc equals pointed nibble: skip; one cycle
// - acc differs from nibble: next executes
// - flag test mode from control bit 0
// - select 0, flag set: clear and skip
// - select 0, flag clear: no skip
// - select 1: pure no-operation
`timescale 1ns/1ps
module skcmp_decoder
    import skcmp_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // fetched word, one per cycle
    input wire logic word_valid,
    input wire skcmp_instr_t word,
    input wire logic next_two_words,
    // core state
    input wire logic [3:0] acc,
    input wire logic [3:0] pointed_memory_nibble,
    input wire logic [3:0] interrupt_control_reg,
    input wire logic ext_int0_request_flag,
    // results
    output logic exec_enable,
    output logic skip_taken,
    output logic ext_int0_flag_clear
);
    skcmp_state_t state_q, state_d;
    logic skip_two_q, skip_two_d;

    // all checks below share the one instruction clock
    default clocking skcmp_cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    // one-hot op test, called only by the decode wires that the checks build on
    function automatic logic op_is(skcmp_instr_t w, skcmp_op_t op);
        return w.op == op;
    endfunction

    wire logic ext_int0_skip_select = interrupt_control_reg[SEL_BIT];
    wire logic in_exec = (state_q == SKCMP_EXEC) && word_valid;
    wire logic in_imm2 = (state_q == SKCMP_IMM2) && word_valid;
    wire logic in_skip = (state_q == SKCMP_SKIP) && word_valid;
    wire logic imm_start = in_exec && op_is(word, SKCMP_OP_IMM);
    wire logic mem_start = in_exec && op_is(word, SKCMP_OP_MEM);
    wire logic flag_start = in_exec && op_is(word, SKCMP_OP_FLAG);

    // immediate operand arrives in the second word, compared in cycle two
    wire logic imm_equal = acc == word.imm;
    wire logic imm_hit = in_imm2 && imm_equal;
    wire logic imm_miss = in_imm2 && !imm_equal;
    wire logic mem_equal = acc == pointed_memory_nibble;
    wire logic mem_hit = mem_start && mem_equal;
    // select high turns the test into a plain no-operation
    wire logic flag_armed = !ext_int0_skip_select && ext_int0_request_flag;
    wire logic flag_hit = flag_start && flag_armed;

    // first skipped word of a two-word instruction keeps the skip alive
    wire logic skip_hold = in_skip && !skip_two_q && next_two_words;
    wire logic skip_done = in_skip && !skip_hold;

    assign skip_taken = imm_hit || mem_hit || flag_hit;
    assign ext_int0_flag_clear = flag_hit;
    // suppressed word still consumes its fetch slot
    assign exec_enable = word_valid && (state_q != SKCMP_SKIP);

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            SKCMP_EXEC: begin
                if (imm_start) begin
                    state_d = SKCMP_IMM2;
                end else if (mem_hit || flag_hit) begin
                    state_d = SKCMP_SKIP;
                end
            end
            SKCMP_IMM2: begin
                if (imm_hit) begin
                    state_d = SKCMP_SKIP;
                end else if (imm_miss) begin
                    state_d = SKCMP_EXEC;
                end
            end
            SKCMP_SKIP: begin
                if (skip_done) begin
                    state_d = SKCMP_EXEC;
                end
            end
            default: state_d = SKCMP_EXEC;
        endcase
    end

    // a stall must not drop the pending second-word skip
    always_comb begin
        skip_two_d = 1'b0;
        if (state_q == SKCMP_SKIP) begin
            skip_two_d = word_valid ? skip_hold : skip_two_q;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_q <= SKCMP_EXEC;
            skip_two_q <= 1'b0;
        end else begin
            state_q <= state_d;
            skip_two_q <= skip_two_d;
        end
    end

    sequence in_skip_s;
        state_q == SKCMP_SKIP;
    endsequence

    sequence back_exec_s;
        state_q == SKCMP_EXEC;
    endsequence

    sequence no_effect_s;
        !skip_taken && !ext_int0_flag_clear;
    endsequence

    property imm_two_cycle;
        imm_start |=> state_q == SKCMP_IMM2;
    endproperty
    imm_enter_a: assert property (imm_two_cycle)
        else $error("imm compare not two cycles");

    property imm_hit_p;
        imm_hit |-> skip_taken ##1 in_skip_s;
    endproperty
    imm_hit_a: assert property (imm_hit_p)
        else $error("imm skip lost");

    property imm_stall_p;
        (state_q == SKCMP_IMM2 && !word_valid) |=> state_q == SKCMP_IMM2;
    endproperty
    imm_stall_a: assert property (imm_stall_p)
        else $error("imm operand wait lost");

    property imm_miss_p;
        imm_miss |-> no_effect_s ##1 back_exec_s;
    endproperty
    imm_miss_a: assert property (imm_miss_p)
        else $error("imm miss skipped");

    property mem_hit_p;
        mem_hit |-> skip_taken ##1 in_skip_s;
    endproperty
    mem_hit_a: assert property (mem_hit_p)
        else $error("mem skip lost");

    property mem_miss_p;
        (mem_start && !mem_equal) |-> no_effect_s ##1 back_exec_s;
    endproperty
    mem_miss_a: assert property (mem_miss_p)
        else $error("mem miss skipped");

    property flag_select_p;
        ext_int0_flag_clear |-> !interrupt_control_reg[0];
    endproperty
    flag_select_a: assert property (flag_select_p)
        else $error("flag clear with select high");

    property flag_clear_p;
        (flag_start && !interrupt_control_reg[0] && ext_int0_request_flag)
            |-> ext_int0_flag_clear && skip_taken ##1 in_skip_s;
    endproperty
    flag_clear_a: assert property (flag_clear_p)
        else $error("flag not cleared");

    property clear_only_p;
        ext_int0_flag_clear |-> skip_taken && state_q == SKCMP_EXEC && ext_int0_request_flag;
    endproperty
    clear_only_a: assert property (clear_only_p)
        else $error("flag clear outside test");

    property flag_zero_p;
        (flag_start && !interrupt_control_reg[0] && !ext_int0_request_flag)
            |-> no_effect_s ##1 back_exec_s;
    endproperty
    flag_zero_a: assert property (flag_zero_p)
        else $error("flag zero skipped");

    property flag_nop_p;
        (flag_start && interrupt_control_reg[0]) |-> no_effect_s ##1 back_exec_s;
    endproperty
    flag_nop_a: assert property (flag_nop_p)
        else $error("nop touched flag");

    property skip_suppress_p;
        skip_taken |=> !exec_enable;
    endproperty
    skip_suppress_a: assert property (skip_suppress_p)
        else $error("skipped word executed");

    property skip_pair_p;
        skip_hold |=> in_skip_s ##0 skip_two_q;
    endproperty
    skip_pair_a: assert property (skip_pair_p)
        else $error("second skipped word lost");

    property skip_stall_p;
        (state_q == SKCMP_SKIP && !word_valid) |=> in_skip_s ##0 $stable(skip_two_q);
    endproperty
    skip_stall_a: assert property (skip_stall_p)
        else $error("stall changed skip state");

    property skip_end_p;
        skip_done |-> !exec_enable && !skip_taken ##1 back_exec_s;
    endproperty
    skip_end_a: assert property (skip_end_p)
        else $error("skip did not end");

    property exec_pass_p;
        state_q != SKCMP_SKIP |-> exec_enable == word_valid;
    endproperty
    exec_pass_a: assert property (exec_pass_p)
        else $error("live word suppressed");

    property state_legal_p;
        $onehot(state_q);
    endproperty
    state_legal_a: assert property (state_legal_p)
        else $error("state code illegal");
endmodule // skcmp_decoder

// ==== sim/skcmp_decoder_tb_top.sv ====
// random bench for the skip-compare decoder
`timescale 1ns/1ps
module skcmp_decoder_tb_top import skcmp_pkg::*; ;
    logic ref_clk = 0, rst = 1, word_valid = 0, next_two_words = 0;
    logic ext_int0_request_flag = 0, e_skip = 0, e_clr = 0;
    logic [3:0] a_pick = 4'h0;
    skcmp_instr_t word = '{SKCMP_OP_OTHER, 4'h0};
    logic [3:0] acc = 4'h0, pointed_memory_nibble = 4'h0, interrupt_control_reg = 4'h0;
    logic exec_enable, skip_taken, ext_int0_flag_clear;
    logic [15:0] lfsr = 16'h37C2;
    int failures = 0, checks_done = 0, cyc = 0, st = 0;
    always #25 ref_clk = ~ref_clk;
    skcmp_decoder uut (.ref_clk(ref_clk), .rst(rst), .word_valid(word_valid), .word(word),
        .next_two_words(next_two_words), .acc(acc), .pointed_memory_nibble(pointed_memory_nibble),
        .interrupt_control_reg(interrupt_control_reg),
        .ext_int0_request_flag(ext_int0_request_flag), .exec_enable(exec_enable),
        .skip_taken(skip_taken), .ext_int0_flag_clear(ext_int0_flag_clear));
    function automatic logic [15:0] nxt(logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    // expected skip of the word now presented, from the bench state
    function automatic logic exp_skip(int s, skcmp_instr_t w, logic [3:0] a, logic [3:0] m,
        logic sel, logic f);
        if (s == 1) return w.imm == a;
        if (s == 0 && w.op == SKCMP_OP_MEM) return a == m;
        if (s == 0 && w.op == SKCMP_OP_FLAG) return !sel && f;
        return 1'b0;
    endfunction
    // one word per rising edge; the model steps on the pre-edge inputs
    task automatic put(logic v, skcmp_op_t op, logic [3:0] im, logic [3:0] a, logic [3:0] m,
        logic [3:0] ctl, logic f, logic two);
        @(posedge ref_clk);
        if (word_valid) st = (st == 2 && next_two_words) ? 3 : e_skip ? 2 :
            (st == 0 && word.op == SKCMP_OP_IMM) ? 1 : 0;
        word_valid <= v;
        word <= '{op, im};
        acc <= a;
        pointed_memory_nibble <= m;
        interrupt_control_reg <= ctl;
        ext_int0_request_flag <= f;
        next_two_words <= two;
    endtask
    task automatic check_bit(string nm, logic exp, logic got);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %b seen %b", nm, exp, got);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            failures++;
            wrap_up();
        end
    end
    // model: 0 execute, 1 immediate word, 2 first skipped word, 3 second skipped word
    always @(negedge ref_clk) begin
        if (!rst) begin
            e_skip = word_valid && exp_skip(st, word, acc, pointed_memory_nibble,
                interrupt_control_reg[0], ext_int0_request_flag);
            e_clr = e_skip && st == 0 && word.op == SKCMP_OP_FLAG;
            check_bit("exec_enable", word_valid && st < 2, exec_enable);
            check_bit("skip_taken", e_skip, skip_taken);
            check_bit("flag_clear", e_clr, ext_int0_flag_clear);
        end
    end
    initial begin
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        // corners: nop select, flag skip over a stalled two-word, imm 15 hit and miss
        put(1'b1, SKCMP_OP_FLAG, 4'h0, 4'h3, 4'h0, 4'h1, 1'b1, 1'b0);
        put(1'b1, SKCMP_OP_FLAG, 4'h0, 4'h3, 4'h0, 4'hE, 1'b1, 1'b0);
        put(1'b1, SKCMP_OP_IMM, 4'h0, 4'h3, 4'h0, 4'h0, 1'b0, 1'b1);
        put(1'b0, SKCMP_OP_OTHER, 4'h0, 4'h3, 4'h0, 4'h0, 1'b0, 1'b0);
        put(1'b1, SKCMP_OP_MEM, 4'h0, 4'h3, 4'h3, 4'h0, 1'b0, 1'b0);
        put(1'b1, SKCMP_OP_IMM, 4'h0, 4'hF, 4'h0, 4'h0, 1'b0, 1'b0);
        put(1'b1, SKCMP_OP_OTHER, 4'hF, 4'hF, 4'h0, 4'h0, 1'b0, 1'b0);
        put(1'b1, SKCMP_OP_OTHER, 4'h0, 4'hF, 4'h0, 4'h0, 1'b0, 1'b0);
        put(1'b1, SKCMP_OP_IMM, 4'h0, 4'hF, 4'h0, 4'h0, 1'b0, 1'b0);
        put(1'b1, SKCMP_OP_OTHER, 4'h2, 4'hF, 4'h0, 4'h0, 1'b0, 1'b0);
        put(1'b1, SKCMP_OP_FLAG, 4'h0, 4'h3, 4'h0, 4'h0, 1'b0, 1'b0);
        $display("corner test done");
        repeat (3000) begin
            lfsr = nxt(lfsr);
            // half the compares forced equal, with 15 as the boundary case
            a_pick = lfsr[12] ? 4'hF : lfsr[11:8];
            put(lfsr[15:13] != 3'h0, skcmp_op_t'(4'h1 << lfsr[1:0]), lfsr[3] ? a_pick : lfsr[7:4],
                a_pick, lfsr[2] ? a_pick : lfsr[7:4], lfsr[9:6], lfsr[4], lfsr[5]);
        end
        $display("random test done");
        wrap_up();
    end
endmodule // skcmp_decoder_tb_top
